// ### hw/oag_core.sv
// Operand and branch address generator with its register file.
//
// Contract
// - Register-indirect jump loads the program counter from the accumulator pair.
// - Direct mode uses the 16-bit immediate unchanged as address.
// - Short direct reaches only the 160-byte window FE80H to FF1FH.
// - Short direct bit 8 is 0 for 80H-FFH, 1 for 00H-1FH.
// - Word short direct form accepts only even addresses.
// - SFR mode indexes the 256-byte space at FF00H by an immediate.
// - SFRs at FF00H-FF1FH go through short direct, not SFR mode.
// - A 3-bit field picks one of eight byte registers.
// - Eight byte registers and four pairs, named by index or function.
// - Register indirect takes the address from the third or base pair.
// - Based mode adds zero-extended offset to base pair, carry dropped.
// - Stack-relative addressing serves push, pop, call, return, interrupts.
// - Stack accesses stay inside the internal high-speed RAM.
// - Internal high-speed RAM spans FE80H to FEFFH.
// - Relative branch adds signed displacement to the next instruction address.
`timescale 1ns/1ps
module oag_core
	import oag_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	input oag_pkg::oag_req_s req_in,
	input wire logic rf_wr_en_in,
	input wire logic rf_wr_pair_in,
	input wire logic [2:0] rf_wr_idx_in,
	input wire logic [15:0] rf_wr_data_in,
	output logic ready_out,
	output oag_pkg::oag_res_s res_out
);
	typedef struct packed {
		oag_state_e st;
		oag_req_s req;
		oag_res_s res;
	} oag_core_s;

	oag_core_s state_ff;
	oag_core_s nxt_state;
	oag_regs_t regs;
	logic [15:0] acc_pair;
	logic [15:0] third_pair;
	logic [15:0] base_pair;
	logic [15:0] based_sum;
	logic [15:0] rel_sum;
	logic [15:0] stack_sum;
	logic [15:0] short_addr;
	logic [15:0] sfr_addr;
	logic short_ok;

	// Register file with byte and pair write port.
	// eight bytes, four pairs
	oag_regfile u_rf (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.wr_en_in(rf_wr_en_in),
		.wr_pair_in(rf_wr_pair_in),
		.wr_idx_in(rf_wr_idx_in),
		.wr_data_in(rf_wr_data_in),
		.regs_out(regs)
	);

	// Pairs are views of byte registers, so both namings hit the same store.
	assign acc_pair = {regs[REG_A], regs[REG_X]};
	assign third_pair = {regs[REG_D], regs[REG_E]};
	assign base_pair = {regs[REG_H], regs[REG_L]};

	oag_add16 #(.WIDTH(16)) u_based (
		.a_in(base_pair),
		.b_in({8'h00, state_ff.req.imm8}),
		.sum_out(based_sum)
	);

	oag_add16 #(.WIDTH(16)) u_rel (
		.a_in(state_ff.req.next_pc),
		.b_in({{8{state_ff.req.imm8[7]}}, state_ff.req.imm8}),
		.sum_out(rel_sum)
	);

	oag_add16 #(.WIDTH(16)) u_stack (
		.a_in(state_ff.req.stack_ptr),
		.b_in(state_ff.req.stack_push ? STACK_PUSH_STEP : STACK_POP_STEP),
		.sum_out(stack_sum)
	);

	// Short direct and SFR address forming; in short direct the immediate 20H-7FH has no target.
	// bit 8 from immediate range
	assign short_ok = (state_ff.req.imm8 >= SADDR_RAM_LOW) ||
		(state_ff.req.imm8 <= SADDR_SFR_TOP);
	assign short_addr = {SADDR_HI_ONES, state_ff.req.imm8 <= SADDR_SFR_TOP,
		state_ff.req.imm8};
	assign sfr_addr = {SFR_PAGE, state_ff.req.imm8};

	// Next-state logic: accept in idle, compute in calc, present in done.
	always_comb begin
		nxt_state = state_ff;
		nxt_state.res = '0;
		case (state_ff.st)
			ST_IDLE: begin
				if (req_valid_in) begin
					nxt_state.req = req_in;
					nxt_state.st = ST_CALC;
				end
			end
			ST_CALC: begin
				nxt_state.st = ST_DONE;
				nxt_state.res.done = 1'b1;
				case (state_ff.req.mode)
					MODE_JUMP_ACC: begin
						nxt_state.res.pc_load = 1'b1;
						nxt_state.res.pc = acc_pair;
					end
					MODE_REL_BRANCH: begin
						nxt_state.res.pc_load = 1'b1;
						nxt_state.res.pc = rel_sum;
					end
					MODE_DIRECT: begin
						nxt_state.res.addr_valid = 1'b1;
						nxt_state.res.addr = state_ff.req.imm16;
					end
					MODE_SHORT, MODE_SHORT_WORD: begin
						nxt_state.res.fault.short_range = !short_ok;
						nxt_state.res.fault.odd_word =
							(state_ff.req.mode == MODE_SHORT_WORD) &&
							state_ff.req.imm8[0];
						nxt_state.res.addr_valid = short_ok &&
							!((state_ff.req.mode == MODE_SHORT_WORD) &&
							state_ff.req.imm8[0]);
						nxt_state.res.addr = short_addr;
					end
					MODE_SFR: begin
						nxt_state.res.fault.sfr_misroute =
							state_ff.req.imm8 <= SADDR_SFR_TOP;
						nxt_state.res.addr_valid =
							state_ff.req.imm8 > SADDR_SFR_TOP;
						nxt_state.res.addr = sfr_addr;
					end
					MODE_REG: begin
						nxt_state.res.opnd_valid = 1'b1;
						nxt_state.res.opnd = {8'h00, regs[state_ff.req.reg_sel]};
					end
					MODE_PAIR: begin
						nxt_state.res.opnd_valid = 1'b1;
						nxt_state.res.opnd = {regs[{state_ff.req.pair_sel, 1'b1}],
							regs[{state_ff.req.pair_sel, 1'b0}]};
					end
					MODE_REG_IND: begin
						// third or base pair as pointer
						nxt_state.res.addr_valid = 1'b1;
						nxt_state.res.addr = (state_ff.req.pair_sel == PAIR_THIRD) ?
							third_pair : base_pair;
					end
					MODE_BASED: begin
						nxt_state.res.addr_valid = 1'b1;
						nxt_state.res.addr = based_sum;
					end
					MODE_STACK: begin
						nxt_state.res.fault.stack_range =
							(stack_sum < RAM_BASE) || (stack_sum > RAM_TOP);
						nxt_state.res.addr_valid =
							(stack_sum >= RAM_BASE) && (stack_sum <= RAM_TOP);
						nxt_state.res.addr = stack_sum;
					end
					default: begin
						nxt_state.res.done = 1'b1;
					end
				endcase
			end
			ST_DONE: begin
				nxt_state.st = ST_IDLE;
			end
			default: begin
				nxt_state.st = ST_IDLE;
			end
		endcase
	end

	// Single state register; the result clears each cycle so it pulses.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= '{st: ST_IDLE, req: '0, res: '0};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign ready_out = state_ff.st[0];
	assign res_out = state_ff.res;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// Request accepted in idle, answer two edges later.
	sequence seq_accept;
		ready_out && req_valid_in;
	endsequence
	sequence seq_answer;
		!res_out.done ##1 res_out.done ##1 (!res_out.done && ready_out);
	endsequence
	property p_handshake;
		seq_accept |=> seq_answer;
	endproperty
	handshake_timing_a: assert property (p_handshake)
		else $error("answer not two cycles after accept");

	jump_acc_a: assert property (
		res_out.done && state_ff.req.mode == MODE_JUMP_ACC |->
		res_out.pc_load && res_out.pc == $past(acc_pair))
		else $error("jump target differs from accumulator pair");

	direct_addr_a: assert property (
		res_out.done && state_ff.req.mode == MODE_DIRECT |->
		res_out.addr_valid && res_out.addr == state_ff.req.imm16)
		else $error("direct address altered");

	short_window_a: assert property (
		res_out.addr_valid && (state_ff.req.mode == MODE_SHORT ||
		state_ff.req.mode == MODE_SHORT_WORD) |->
		res_out.addr >= RAM_BASE && res_out.addr <= SADDR_TOP)
		else $error("short address outside window");

	short_bit8_a: assert property (
		res_out.addr_valid && state_ff.req.mode == MODE_SHORT |->
		res_out.addr[8] == (state_ff.req.imm8 <= SADDR_SFR_TOP) &&
		res_out.addr[15:9] == SADDR_HI_ONES &&
		res_out.addr[7:0] == state_ff.req.imm8)
		else $error("short address bits wrong");

	word_even_a: assert property (
		res_out.done && state_ff.req.mode == MODE_SHORT_WORD |->
		res_out.addr_valid != (res_out.fault.odd_word || res_out.fault.short_range)
		&& !(res_out.addr_valid && res_out.addr[0]))
		else $error("odd word short address accepted");

	sfr_addr_a: assert property (
		res_out.addr_valid && state_ff.req.mode == MODE_SFR |->
		res_out.addr == {SFR_PAGE, state_ff.req.imm8})
		else $error("sfr address wrong");

	sfr_low_a: assert property (
		res_out.done && state_ff.req.mode == MODE_SFR &&
		state_ff.req.imm8 <= SADDR_SFR_TOP |->
		!res_out.addr_valid && res_out.fault.sfr_misroute)
		else $error("low sfr reached through sfr mode");

	reg_select_a: assert property (
		res_out.done && state_ff.req.mode == MODE_REG |->
		res_out.opnd == {8'h00, $past(regs[state_ff.req.reg_sel])})
		else $error("wrong byte register");

	reg_ind_a: assert property (
		res_out.done && state_ff.req.mode == MODE_REG_IND |->
		res_out.addr == (state_ff.req.pair_sel == PAIR_THIRD ?
		$past(third_pair) : $past(base_pair)))
		else $error("indirect address from wrong pair");

	based_sum_a: assert property (
		res_out.done && state_ff.req.mode == MODE_BASED |->
		res_out.addr == 16'($past(base_pair) + {8'h00, state_ff.req.imm8}))
		else $error("based address wrong");

	stack_range_a: assert property (
		res_out.addr_valid && state_ff.req.mode == MODE_STACK |->
		res_out.addr >= RAM_BASE && res_out.addr <= RAM_TOP)
		else $error("stack address outside ram");

	rel_branch_a: assert property (
		res_out.done && state_ff.req.mode == MODE_REL_BRANCH |->
		res_out.pc_load && res_out.pc == 16'(state_ff.req.next_pc +
		{{8{state_ff.req.imm8[7]}}, state_ff.req.imm8}))
		else $error("relative branch target wrong");
endmodule // oag_core

// ### hw/oag_pkg.sv
// Shared types and constants of the operand address generator.
package oag_pkg;
	localparam int unsigned NUM_BYTE_REGS = 8;
	localparam logic [6:0] SADDR_HI_ONES = 7'h7f;
	localparam logic [7:0] SFR_PAGE = 8'hff;
	localparam logic [7:0] SADDR_SFR_TOP = 8'h1f;
	localparam logic [7:0] SADDR_RAM_LOW = 8'h80;
	localparam logic [15:0] RAM_BASE = 16'hfe80;
	localparam logic [15:0] RAM_TOP = 16'hfeff;
	localparam logic [15:0] SADDR_TOP = 16'hff1f;
	localparam logic [15:0] STACK_PUSH_STEP = 16'hffff;
	localparam logic [15:0] STACK_POP_STEP = 16'h0000;
	// Byte register absolute indices with their function names.
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [2:0] REG_E = 3'h4;
	localparam logic [2:0] REG_D = 3'h5;
	localparam logic [2:0] REG_L = 3'h6;
	localparam logic [2:0] REG_H = 3'h7;
	// Pair absolute indices: 0 accumulator, 1 second, 2 third, 3 base.
	localparam logic [1:0] PAIR_THIRD = 2'h2;
	localparam logic [1:0] PAIR_BASE = 2'h3;

	typedef enum logic [3:0] {
		MODE_JUMP_ACC = 4'h0,
		MODE_REL_BRANCH = 4'h1,
		MODE_DIRECT = 4'h2,
		MODE_SHORT = 4'h3,
		MODE_SHORT_WORD = 4'h4,
		MODE_SFR = 4'h5,
		MODE_REG = 4'h6,
		MODE_PAIR = 4'h7,
		MODE_REG_IND = 4'h8,
		MODE_BASED = 4'h9,
		MODE_STACK = 4'ha
	} oag_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CALC = 3'b010,
		ST_DONE = 3'b100
	} oag_state_e;

	typedef struct packed {
		oag_mode_e mode;
		logic [15:0] imm16;
		logic [7:0] imm8;
		logic [2:0] reg_sel;
		logic [1:0] pair_sel;
		logic stack_push;
		logic [15:0] next_pc;
		logic [15:0] stack_ptr;
	} oag_req_s;

	typedef struct packed {
		logic stack_range;
		logic short_range;
		logic odd_word;
		logic sfr_misroute;
	} oag_fault_s;

	typedef struct packed {
		logic done;
		logic addr_valid;
		logic [15:0] addr;
		logic pc_load;
		logic [15:0] pc;
		logic opnd_valid;
		logic [15:0] opnd;
		oag_fault_s fault;
	} oag_res_s;

	typedef logic [NUM_BYTE_REGS-1:0][7:0] oag_regs_t;
endpackage

// ### hw/oag_add16.sv
// Modulo adder used for based, relative and stack address sums.
`timescale 1ns/1ps
module oag_add16 #(
	parameter int unsigned WIDTH = 16
) (
	input wire logic [WIDTH-1:0] a_in,
	input wire logic [WIDTH-1:0] b_in,
	output logic [WIDTH-1:0] sum_out
);
	// Carry out of the top bit is dropped on purpose; addresses wrap.
	always_comb begin
		sum_out = a_in + b_in;
	end
endmodule // oag_add16

// ### hw/oag_regfile.sv
// Eight byte registers, writable as bytes or as pairs.
`timescale 1ns/1ps
module oag_regfile
	import oag_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic wr_pair_in,
	input wire logic [2:0] wr_idx_in,
	input wire logic [15:0] wr_data_in,
	output oag_pkg::oag_regs_t regs_out
);
	oag_regs_t regs_ff;
	oag_regs_t nxt_regs;

	// A pair write puts the low byte at the even index, high at odd.
	always_comb begin
		nxt_regs = regs_ff;
		if (wr_en_in && wr_pair_in) begin
			nxt_regs[{wr_idx_in[1:0], 1'b0}] = wr_data_in[7:0];
			nxt_regs[{wr_idx_in[1:0], 1'b1}] = wr_data_in[15:8];
		end else if (wr_en_in) begin
			nxt_regs[wr_idx_in] = wr_data_in[7:0];
		end
	end

	// All registers clear at reset.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			regs_ff <= '0;
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	assign regs_out = regs_ff;
endmodule // oag_regfile

// ### dv/tb.sv
// Self-checking testbench of the operand address generator core.
`timescale 1ns/1ps
module tb;
	import oag_pkg::*;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	oag_req_s req = '0;
	logic wr_en = 1'b0;
	logic wr_pair = 1'b0;
	logic [2:0] wr_idx = 3'h0;
	logic [15:0] wr_data = 16'h0000;
	logic ready_out;
	oag_res_s res_out;
	oag_res_s res;
	int n_fail = 0;
	int tests_run = 0;
	logic [7:0] tbl [6] = '{8'h80, 8'hff, 8'h00, 8'h1f, 8'h20, 8'h7f};

	oag_core dut_u (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.req_valid_in(req_valid_in),
		.req_in(req),
		.rf_wr_en_in(wr_en),
		.rf_wr_pair_in(wr_pair),
		.rf_wr_idx_in(wr_idx),
		.rf_wr_data_in(wr_data),
		.ready_out(ready_out),
		.res_out(res_out)
	);

	// A 25 MHz clock, so each half period is 20 ns.
	always #20 clock_in = ~clock_in;

	// Compares a seen value with the expected one; four-state so X never matches.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One register file write, then one idle cycle so back-to-back calls never
	// lower and raise the enable in the same time step.
	task automatic wr(input logic p, input logic [2:0] i, input logic [15:0] d);
		wr_en = 1'b1;
		wr_pair = p;
		wr_idx = i;
		wr_data = d;
		@(negedge clock_in);
		wr_en = 1'b0;
		@(negedge clock_in);
	endtask

	// One request; the answer is captured in res in the cycle it stands.
	task automatic run(input oag_mode_e m, input logic [15:0] i16, input logic [7:0] i8,
			input logic [2:0] sel, input logic push, input logic [15:0] npc,
			input logic [15:0] sp);
		oag_req_s r;
		r = '0;
		r.mode = m;
		r.imm16 = i16;
		r.imm8 = i8;
		r.reg_sel = sel;
		r.pair_sel = sel[1:0];
		r.stack_push = push;
		r.next_pc = npc;
		r.stack_ptr = sp;
		// The request is built aside so the port changes only once.
		req = r;
		req_valid_in = 1'b1;
		@(negedge clock_in);
		req_valid_in = 1'b0;
		chk(ready_out, 0);
		// The answer stands only in the cycle after the calc cycle.
		@(negedge clock_in);
		res = res_out;
		chk(res.done, 1);
		@(negedge clock_in);
		chk(res_out.done, 0);
		chk(ready_out, 1);
	endtask

	// Byte registers by absolute index, then the four pairs built from them.
	task automatic t_regs();
		for (int i = 0; i < 8; i++) begin
			wr(1'b0, 3'(i), {8'h00, 8'(8'h10 + i)});
		end
		for (int i = 0; i < 8; i++) begin
			run(MODE_REG, 16'h0, 8'h0, 3'(i), 1'b0, 16'h0, 16'h0);
			chk({res.opnd_valid, res.opnd}, {1'b1, 8'h00, 8'(8'h10 + i)});
		end
		for (int p = 0; p < 4; p++) begin
			run(MODE_PAIR, 16'h0, 8'h0, 3'(p), 1'b0, 16'h0, 16'h0);
			chk(res.opnd, {8'(8'h11 + 2 * p), 8'(8'h10 + 2 * p)});
		end
	endtask

	// Jump loads the program counter from the accumulator pair.
	task automatic t_jump();
		run(MODE_JUMP_ACC, 16'h0, 8'h0, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.pc_load, res.pc}, {1'b1, 16'h1110});
	endtask

	// Direct and special register forms, including the low area refusal.
	task automatic t_direct_sfr();
		run(MODE_DIRECT, 16'habcd, 8'h0, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.addr}, {1'b1, 16'habcd});
		run(MODE_SFR, 16'h0, 8'h20, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.addr, res.fault}, {1'b1, 16'hff20, 4'b0000});
		run(MODE_SFR, 16'h0, 8'h1f, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.fault}, {1'b0, 4'b0001});
		// An unused mode code must answer with the done marker and nothing else.
		run(oag_mode_e'(4'hb), 16'hffff, 8'hff, 3'h7, 1'b1, 16'hffff, 16'hfe90);
		chk(res, {1'b1, 55'h0});
	endtask

	// Short window edges and the gap between its two parts.
	task automatic t_short();
		logic bad;
		foreach (tbl[k]) begin
			bad = (tbl[k] >= 8'h20) && (tbl[k] < 8'h80);
			run(MODE_SHORT, 16'h0, tbl[k], 3'h0, 1'b0, 16'h0, 16'h0);
			chk({res.addr_valid, res.fault}, {~bad, 1'b0, bad, 2'b00});
			if (!bad) begin
				chk(res.addr, {7'h7f, ~tbl[k][7], tbl[k]});
			end
		end
		run(MODE_SHORT_WORD, 16'h0, 8'h81, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.fault}, {1'b0, 4'b0010});
		run(MODE_SHORT_WORD, 16'h0, 8'h1e, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.addr}, {1'b1, 16'hff1e});
	endtask

	// Indirect, based with dropped carry, and relative branches.
	task automatic t_ind_based_rel();
		wr(1'b1, 3'h2, 16'hfe90);
		wr(1'b1, 3'h3, 16'hfff0);
		run(MODE_REG_IND, 16'h0, 8'h0, 3'h2, 1'b0, 16'h0, 16'h0);
		chk({res.addr_valid, res.addr}, {1'b1, 16'hfe90});
		run(MODE_REG_IND, 16'h0, 8'h0, 3'h3, 1'b0, 16'h0, 16'h0);
		chk(res.addr, 16'hfff0);
		run(MODE_BASED, 16'h0, 8'h20, 3'h0, 1'b0, 16'h0, 16'h0);
		chk(res.addr, 16'h0010);
		run(MODE_BASED, 16'h0, 8'h8f, 3'h0, 1'b0, 16'h0, 16'h0);
		chk(res.addr, 16'h007f);
		run(MODE_REL_BRANCH, 16'h0, 8'h80, 3'h0, 1'b0, 16'h1000, 16'h0);
		chk({res.pc_load, res.pc}, {1'b1, 16'h0f80});
		run(MODE_REL_BRANCH, 16'h0, 8'h7f, 3'h0, 1'b0, 16'h1000, 16'h0);
		chk(res.pc, 16'h107f);
	endtask

	// Stack pushes and pops at both ends of the fast RAM.
	task automatic t_stack();
		run(MODE_STACK, 16'h0, 8'h0, 3'h0, 1'b1, 16'h0, 16'hfe81);
		chk({res.addr_valid, res.addr}, {1'b1, 16'hfe80});
		run(MODE_STACK, 16'h0, 8'h0, 3'h0, 1'b0, 16'h0, 16'hfeff);
		chk({res.addr_valid, res.addr}, {1'b1, 16'hfeff});
		run(MODE_STACK, 16'h0, 8'h0, 3'h0, 1'b1, 16'h0, 16'hfe80);
		chk({res.addr_valid, res.fault}, {1'b0, 4'b1000});
		run(MODE_STACK, 16'h0, 8'h0, 3'h0, 1'b0, 16'h0, 16'hff00);
		chk({res.addr_valid, res.fault}, {1'b0, 4'b1000});
	endtask

	// A reset in mid-run must clear the registers and leave the core idle.
	task automatic t_reset();
		wr(1'b1, 3'h0, 16'h1234);
		rst_in = 1'b1;
		@(negedge clock_in);
		chk(ready_out, 1);
		chk(res_out, '0);
		rst_in = 1'b0;
		@(negedge clock_in);
		run(MODE_JUMP_ACC, 16'h0, 8'h0, 3'h0, 1'b0, 16'h0, 16'h0);
		chk({res.pc_load, res.pc}, {1'b1, 16'h0000});
	endtask

	// The whole run needs about 140 cycles; two thousand is ample margin.
	initial begin
		#80000;
		n_fail++;
		print_verdict();
	end

	// Main sequence: reset for four cycles, then every scenario in turn.
	initial begin
		repeat (4) @(negedge clock_in);
		chk({ready_out, res_out}, {1'b1, {$bits(oag_res_s){1'b0}}});
		rst_in = 1'b0;
		@(negedge clock_in);
		t_regs();
		t_jump();
		t_direct_sfr();
		t_short();
		t_ind_based_rel();
		t_stack();
		t_reset();
		print_verdict();
	end
endmodule // tb
